/* dv/pmrc_asserts.sv */
`default_nettype none
module pmrc_asserts #(
  parameter int IRQ_W = 8
) (
  input wire logic               clock_i,     // system clock
  input wire logic               rst_i,       // async reset
  input wire logic               hreadyout_o, // slave ready
  input wire logic               hresp_o,     // response
  input wire pmrc_pkg::reset_src_s reset_src_i, // reset sources
  input wire logic [IRQ_W-1:0]   irq_request_i, // pending irqs
  input wire logic [IRQ_W-1:0]   irq_enable_i, // irq enables
  input wire logic               global_interrupt_enable_i, // ea
  input wire logic               system_reset_o, // internal reset
  input wire logic               cpu_start_o, // start pulse
  input wire logic               wake_o,      // wake pulse
  input wire logic               wake_to_isr_o, // vector pulse
  input wire pmrc_pkg::power_ctl_s power_ctl_o, // clock gating
  input wire pmrc_pkg::cpu_boot_s  cpu_boot_o   // cpu reset load
);
  import pmrc_pkg::*;
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  logic       src_hot;
  logic [7:0] low_cnt_r;
  assign src_hot = reset_src_i.poweron | reset_src_i.watchdog_ovf
                 | reset_src_i.brownout | reset_src_i.debug_req;
  // raw pin low run length
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) low_cnt_r <= 8'h00;
    else if (reset_src_i.pin_n) low_cnt_r <= 8'h00;
    else if (low_cnt_r != 8'hFF) low_cnt_r <= low_cnt_r + 8'h01;
  end
  bus_okay_a: assert property (hreadyout_o && !hresp_o)
    else $error("bus not okay");
  stop_gate_a: assert property (power_ctl_o.clock_stop |->
    power_ctl_o.cpu_halt && !power_ctl_o.periph_clock_en)
    else $error("bad stop gating");
  wake_clear_a: assert property (power_ctl_o.cpu_halt && !src_hot
    && !system_reset_o && |(irq_request_i & irq_enable_i)
    |=> wake_o && !power_ctl_o.cpu_halt) else $error("no wake");
  wake_vector_a: assert property (wake_o || wake_to_isr_o |->
    wake_o && wake_to_isr_o == $past(global_interrupt_enable_i))
    else $error("vector pulse wrong");
  boot_load_a: assert property (system_reset_o && $past(system_reset_o)
    |-> cpu_boot_o == {PC_RESET, ACC_RESET, SP_RESET}
    && power_ctl_o.periph_clock_en) else $error("bad reset load");
  start_pulse_a: assert property (cpu_start_o == $fell(system_reset_o))
    else $error("bad start pulse");
  process_len_a: assert property ($fell(system_reset_o) |->
    $past(system_reset_o, 5)) else $error("processing too short");
  source_reset_a: assert property (reset_src_i.poweron
    || reset_src_i.debug_req |=> system_reset_o) else $error("no reset");
  pin_noise_a: assert property ($rose(system_reset_o) |->
    $past(src_hot) || low_cnt_r >= 8'hBE) else $error("short pin reset");
endmodule
bind power_mode_and_reset_control pmrc_asserts #(.IRQ_W(IRQ_W)) i_pmrc_asserts (
  .clock_i(clock_i), .rst_i(rst_i), .hreadyout_o(hreadyout_o),
  .hresp_o(hresp_o), .reset_src_i(reset_src_i),
  .irq_request_i(irq_request_i), .irq_enable_i(irq_enable_i),
  .global_interrupt_enable_i(global_interrupt_enable_i),
  .system_reset_o(system_reset_o), .cpu_start_o(cpu_start_o),
  .wake_o(wake_o), .wake_to_isr_o(wake_to_isr_o),
  .power_ctl_o(power_ctl_o), .cpu_boot_o(cpu_boot_o));
`default_nettype wire

/* dv/pmrc_far_side.sv */
`default_nettype none
module pmrc_far_side (
  input  wire logic           clock_i,  // system clock
  output var pmrc_pkg::reset_src_s src_o, // reset sources
  output logic [7:0]          irq_o,    // pending irqs
  output logic [7:0]          irq_en_o, // per-irq enable
  output logic                ea_o,     // global enable
  output logic [7:0]          option_o  // stored options
);
  import pmrc_pkg::*;
  // idle: pin high, detectors low
  localparam logic [4:0] QUIET = 5'h08;
  // irqs 2, 3 enabled
  assign irq_en_o = 8'h0C;
  assign option_o = 8'hA5;
  initial begin
    src_o = QUIET;
    irq_o = 8'h00;
    ea_o = 1'b0;
  end
  // sources m active for n cycles
  task automatic pulse(input logic [4:0] m, input int n);
    src_o <= QUIET ^ m;
    repeat (n) @(posedge clock_i);
    src_o <= QUIET;
  endtask
  // one-cycle requests r, global enable e
  task automatic irq(input logic e, input logic [7:0] r);
    ea_o <= e;
    irq_o <= r;
    @(posedge clock_i);
    irq_o <= 8'h00;
  endtask
endmodule
`default_nettype wire

/* dv/power_mode_and_reset_control_bench.sv */
`default_nettype none
module power_mode_and_reset_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import pmrc_pkg::*;
  localparam logic [4:0] S_POR = 5'h10, S_PIN = 5'h08, S_WDT = 5'h04;
  localparam logic [4:0] S_BO = 5'h02, S_DBG = 5'h01;
  logic        clock_i, rst_i, hsel, hwrite, hready, hresp, ea, bo_en;
  logic        system_reset, cpu_start, wake, wake_isr, config_ok;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic [31:0] hwdata, hrdata;
  logic [7:0]  irq, irq_en, option, config_val, lowvolt;
  logic [3:0]  bo_level;
  reset_src_s  src;
  power_ctl_s  pctl;
  cpu_boot_s   boot;
  int          num_errors, n_tests, cycles;
  power_mode_and_reset_control #(.POWERUP_DELAY_US(3), .RELEASE_DELAY_US(4))
  i_power_mode_and_reset_control (
    .clock_i(clock_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(HSIZE_WORD),
    .hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hready),
    .hresp_o(hresp), .hrdata_o(hrdata), .reset_src_i(src),
    .irq_request_i(irq), .irq_enable_i(irq_en),
    .global_interrupt_enable_i(ea), .config_option_i(option),
    .system_reset_o(system_reset), .cpu_start_o(cpu_start), .wake_o(wake),
    .wake_to_isr_o(wake_isr), .power_ctl_o(pctl), .cpu_boot_o(boot),
    .config_o(config_val), .config_valid_o(config_ok),
    .brownout_level_select_o(bo_level), .brownout_enable_o(bo_en),
    .lowvolt_indicator_o(lowvolt));
  pmrc_far_side i_pmrc_far_side (.clock_i(clock_i), .src_o(src),
    .irq_o(irq), .irq_en_o(irq_en), .ea_o(ea), .option_o(option));
  // 100 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  task automatic give_verdict;
    if (num_errors == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // one word transfer; q is read byte
  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [7:0] d, output logic [7:0] q);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {2'b00, idx, 2'b00};
    do @(posedge clock_i); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {24'h000000, d};
    do @(posedge clock_i); while (hready !== 1'b1);
    q = hrdata[7:0];
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, idx, d, q);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    bus(1'b0, idx, 8'h00, q);
    check(q, exp);
  endtask
  // wait for start, count cycles; cfg is expected option valid
  task automatic wait_run(input logic cfg, output int n);
    n = 0;
    while (cpu_start !== 1'b1 && n < 3000) begin
      @(posedge clock_i);
      n++;
      if (n == 100) check(config_ok, cfg);
    end
    check(cpu_start, 1'b1);
  endtask
  task automatic quiet;
    repeat (20) @(posedge clock_i);
    check(system_reset, 1'b0);
  endtask
  task automatic t_modes;
    logic [7:0] m [4] = '{8'h01, 8'h03, 8'h02, 8'h07};
    foreach (m[i]) begin
      wr(IDX_POWER_MODE, m[i]);
      repeat (3) @(posedge clock_i);
      check(pctl, m[i] == PMODE_IDLE ? 3'b101 :
                  m[i] == PMODE_STOP ? 3'b110 : 3'b001);
      if (pctl.cpu_halt === 1'b1) begin
        i_pmrc_far_side.irq(~m[i][1], 8'h01);
        @(posedge clock_i);
        check({wake, pctl.cpu_halt}, 2'b01);
        i_pmrc_far_side.irq(~m[i][1], 8'h04);
        @(posedge clock_i);
        check({wake, wake_isr, pctl}, {1'b1, ~m[i][1], 3'b001});
        rd(IDX_POWER_MODE, PMODE_NORMAL);
      end
    end
  endtask
  task automatic t_cause;
    int n;
    rd(IDX_CAUSE, 8'h80);
    wr(IDX_CAUSE, 8'hFF);
    rd(IDX_CAUSE, 8'h80);
    wr(IDX_CAUSE, 8'h00);
    rd(IDX_CAUSE, 8'h00);
    i_pmrc_far_side.pulse(S_DBG, 3);
    wait_run(1'b1, n);
    rd(IDX_CAUSE, 8'h10);
    i_pmrc_far_side.pulse(S_WDT, 3);
    quiet;
    wr(IDX_WDT_CTRL, 8'h01);
    i_pmrc_far_side.pulse(S_WDT, 3);
    wait_run(1'b1, n);
    rd(IDX_CAUSE, 8'h30);
    wr(IDX_BROWNOUT, 8'h01);
    i_pmrc_far_side.pulse(S_BO, 3);
    quiet;
    wr(IDX_BROWNOUT, 8'h1A);
    @(posedge clock_i);
    check({bo_level, bo_en}, 5'h1B);
    i_pmrc_far_side.pulse(S_BO, 3);
    wait_run(1'b1, n);
    rd(IDX_CAUSE, 8'h38);
    rd(IDX_BROWNOUT, 8'h1A);
    i_pmrc_far_side.pulse(S_PIN, 150);
    quiet;
    i_pmrc_far_side.pulse(S_PIN, 1000);
    wait_run(1'b1, n);
    rd(IDX_CAUSE, 8'h78);
    wr(IDX_CAUSE, 8'h08);
    rd(IDX_CAUSE, 8'h08);
    rd(8'h10, 8'h00);
    i_pmrc_far_side.pulse(S_POR, 3);
    wait_run(1'b0, n);
    rd(IDX_CAUSE, 8'h80);
    rd(IDX_BROWNOUT, 8'h00);
  endtask
  // hang limit
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      give_verdict;
    end
  end
  // main sequence
  initial begin
    int n;
    num_errors = 0;
    n_tests = 0;
    cycles = 0;
    rst_i = 1'b1;
    hsel = 1'b0;
    htrans = 2'b00;
    repeat (10) @(posedge clock_i);
    check(system_reset, 1'b1);
    check(boot, {PC_RESET, ACC_RESET, SP_RESET});
    rst_i <= 1'b0;
    wait_run(1'b0, n);
    check(n >= 700 && n <= 712, 1'b1);
    check(config_val, 8'hA5);
    t_modes;
    t_cause;
    give_verdict;
  end
endmodule
`default_nettype wire

/* verilog/interval_timer.sv */
`default_nettype none
module interval_timer #(
  parameter int WIDTH = 16
) (
  input  wire logic             clock_i,  // system clock
  input  wire logic             rst_i,    // async reset, active high
  input  wire logic             clear_i,  // restart from zero
  input  wire logic             tick_i,   // count enable pulse
  input  wire logic [WIDTH-1:0] limit_i,  // ticks to run
  output logic                  done_o    // limit reached
);
  import pmrc_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] cnt;
    logic             done;
  } tmr_s;

  tmr_s st_r;
  tmr_s st_nxt;

  if (WIDTH < 2) begin : g_chk
    $error("timer width too small");
  end

  // saturating tick counter
  always_comb begin
    st_nxt = st_r;
    if (clear_i) begin
      st_nxt = '0;
    end else if (tick_i && !st_r.done) begin
      st_nxt.cnt  = st_r.cnt + WIDTH'(1);
      st_nxt.done = (st_nxt.cnt >= limit_i);
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign done_o = st_r.done;
endmodule
`default_nettype wire

/* verilog/pmrc_pkg.sv */
`default_nettype none
package pmrc_pkg;

  // register indices; byte address = 4 * index
  localparam int          ADDR_W             = 12;
  localparam logic [7:0]  IDX_LOWVOLT        = 8'h86;
  localparam logic [7:0]  IDX_POWER_MODE     = 8'h87;
  localparam logic [7:0]  IDX_BROWNOUT       = 8'hD8;
  localparam logic [7:0]  IDX_CAUSE          = 8'hE8;
  localparam logic [7:0]  IDX_WDT_CTRL       = 8'hF0;

  // power mode register values
  localparam logic [7:0]  PMODE_NORMAL       = 8'h00;
  localparam logic [7:0]  PMODE_IDLE         = 8'h01;
  localparam logic [7:0]  PMODE_STOP         = 8'h03;

  // reset cause register layout
  localparam logic [7:0]  CAUSE_RESET        = 8'h80;
  localparam logic [7:0]  CAUSE_IMPL_MASK    = 8'hF8;
  localparam int          CAUSE_POR_BIT      = 7;
  localparam int          CAUSE_PIN_BIT      = 6;
  localparam int          CAUSE_WDT_BIT      = 5;
  localparam int          CAUSE_DBG_BIT      = 4;
  localparam int          CAUSE_BOD_BIT      = 3;

  // brown-out register layout
  localparam logic [7:0]  BROWNOUT_RESET     = 8'h00;
  localparam logic [7:0]  BROWNOUT_MASK      = 8'h9F;
  localparam logic [7:0]  BROWNOUT_LVL_MASK  = 8'h1E;
  localparam int          BO_DIS_BIT         = 0;
  localparam int          BO_LVL_LSB         = 1;
  localparam int          BO_LVL_W           = 4;
  localparam int          BO_STOP_EN_BIT     = 7;

  // indicator and watchdog control
  localparam logic [7:0]  LOWVOLT_RESET      = 8'h00;
  localparam logic [7:0]  LOWVOLT_MASK       = 8'h3F;
  localparam logic [7:0]  WDT_CTRL_RESET     = 8'h00;
  localparam logic [7:0]  WDT_CTRL_MASK      = 8'h01;
  localparam int          WDT_EN_BIT         = 0;

  // cpu state loaded by reset
  localparam logic [15:0] PC_RESET           = 16'h0000;
  localparam logic [7:0]  ACC_RESET          = 8'h00;
  localparam logic [7:0]  SP_RESET           = 8'h07;

  // bus constants
  localparam logic [2:0]  HSIZE_WORD         = 3'h2;
  localparam logic        HRESP_OKAY         = 1'h0;

  // timing
  localparam int          CLK_MHZ            = 100;
  localparam int          NOISE_NS           = 2000;
  localparam int          NOISE_CYCLES       = NOISE_NS * CLK_MHZ / 1000;
  localparam int          US_NS              = 1000;
  localparam int          US_TICK_CYCLES     = US_NS * CLK_MHZ / 1000;
  localparam int          DIV_W              = $clog2(US_TICK_CYCLES);
  localparam int          BOOT_OSC_MHZ       = 8;
  localparam int          BOOT_OSC_DIV       = 8;
  localparam int          BOOT_PRESCALE      = 256;
  localparam int          BOOT_MULT          = 'h28;
  localparam int          BOOT_DELAY_US      =
    BOOT_PRESCALE * BOOT_MULT * BOOT_OSC_DIV / BOOT_OSC_MHZ;
  localparam int          RELEASE_MS         = 16;
  localparam int          RELEASE_DELAY_US   = RELEASE_MS * 1000;
  localparam int          RESET_PROC_CYCLES  = 5;

  // reset sequencer states
  typedef enum logic [2:0] {
    SEQ_POR_WAIT,
    SEQ_CONFIG,
    SEQ_STABILIZE,
    SEQ_PROCESS,
    SEQ_RUN
  } seq_state_e;

  // raw reset sources
  typedef struct packed {
    logic poweron;
    logic pin_n;
    logic watchdog_ovf;
    logic brownout;
    logic debug_req;
  } reset_src_s;

  // clock and cpu gating
  typedef struct packed {
    logic cpu_halt;
    logic clock_stop;
    logic periph_clock_en;
  } power_ctl_s;

  // cpu reset load
  typedef struct packed {
    logic [15:0] pc;
    logic [7:0]  acc;
    logic [7:0]  sp;
  } cpu_boot_s;

endpackage
`default_nettype wire

/* verilog/power_mode_and_reset_control.sv */
// Overview of operation
// R01: global enable set: enabled interrupt ends stop and vectors.
// R02: enabled interrupt ends stop with global enable clear.
// R03: mode 01H: cpu halts in idle, clocks run.
// R04: mode 03H: stop, clocks halted, state kept.
// R05: other mode values: normal run.
// R06: wake-up clears the power mode register.
// R07: firmware puts three no-ops after the mode write.
// R08: reset loads pc 0000h, acc 00h, sp 07h, peripheral clock on.
// R09: system reset gathers pin, power-on, watchdog, brown-out, debug.
// R10: watchdog overflow resets only while watchdog enable is 1.
// R11: brown-out resets only while brown-out disable bit is 0.
// R12: pin low pulses under about 2us are ignored.
// R13: after power-on, wait about 10ms before reading configuration.
// R14: configuration is read and applied before release.
// R15: release 16ms after power-on or pin release; after power-on the code counts the 16ms from the configuration read.
// R16: pin reset must be held low at least 10us.
// R17: five clocks of reset processing, then start at 0000H.
// R18: four-bit select picks one of fourteen brown-out levels.
// R19: cause register resets to 80H; write 0 clears power-on flag.
// R20: pin flag set by pin reset, cleared by write 0 or power-on.
// R21: watchdog flag set by watchdog reset, cleared likewise.
// R22: debug flag set by debug reset, cleared likewise.
// R23: a non power-on reset sets only its own flag.
// R24: brown-out flag set by brown-out reset, cleared likewise.
// R25: writing 1 keeps a flag; unimplemented cause bits read zero.
//
// Our own choice: register access over AHB-Lite.
`default_nettype none
module power_mode_and_reset_control #(
  parameter int IRQ_W            = 8,
  parameter int TIMER_W          = 16,
  parameter int POWERUP_DELAY_US = pmrc_pkg::BOOT_DELAY_US,
  parameter int RELEASE_DELAY_US = pmrc_pkg::RELEASE_DELAY_US
) (
  input  wire logic                        clock_i,      // 100 MHz clock
  input  wire logic                        rst_i,        // async reset
  input  wire logic                        hsel_i,       // slave select
  input  wire logic [pmrc_pkg::ADDR_W-1:0] haddr_i,      // byte address
  input  wire logic [1:0]                  htrans_i,     // transfer type
  input  wire logic                        hwrite_i,     // write access
  input  wire logic [2:0]                  hsize_i,      // transfer size
  input  wire logic [31:0]                 hwdata_i,     // write data
  input  wire logic                        hready_i,     // bus ready
  output logic                             hreadyout_o,  // slave ready
  output logic                             hresp_o,      // response
  output logic [31:0]                      hrdata_o,     // read data
  input  wire pmrc_pkg::reset_src_s        reset_src_i,  // reset sources
  input  wire logic [IRQ_W-1:0]            irq_request_i, // pending irqs
  input  wire logic [IRQ_W-1:0]            irq_enable_i, // per-irq enable
  input  wire logic                        global_interrupt_enable_i, // EA
  input  wire logic [7:0]                  config_option_i, // option bits
  output logic                             system_reset_o, // internal rst
  output logic                             cpu_start_o,  // fetch 0000H
  output logic                             wake_o,       // wake pulse
  output logic                             wake_to_isr_o, // vector pulse
  output pmrc_pkg::power_ctl_s             power_ctl_o,  // clock gating
  output pmrc_pkg::cpu_boot_s              cpu_boot_o,   // cpu reset load
  output logic [7:0]                       config_o,     // applied option
  output logic                             config_valid_o, // option read
  output logic [pmrc_pkg::BO_LVL_W-1:0]    brownout_level_select_o, // lvl
  output logic                             brownout_enable_o, // detector on
  output logic [7:0]                       lowvolt_indicator_o // lvi ctrl
);
  import pmrc_pkg::*;

  typedef struct packed {
    seq_state_e        seq;
    logic [2:0]        proc_cnt;
    logic [DIV_W-1:0]  div_cnt;
    logic [7:0]        power_mode;
    logic [7:0]        cause;
    logic [7:0]        brownout;
    logic [7:0]        lowvolt;
    logic [7:0]        wdt_ctrl;
    logic [ADDR_W-1:0] addr;
    logic              wr_pend;
    logic [31:0]       rdata;
    logic [7:0]        config_opt;
    logic              cfg_valid;
    cpu_boot_s         boot;
    logic              start;
    logic              wake;
    logic              wake_isr;
  } ctl_s;

  ctl_s st_r;
  ctl_s st_nxt;

  logic               pin_filt_n;
  logic               timer_clear;
  logic               timer_done;
  logic [TIMER_W-1:0] timer_limit;
  logic               us_tick;

  if (POWERUP_DELAY_US < 1 || POWERUP_DELAY_US >= (1 << TIMER_W) ||
      RELEASE_DELAY_US < 1 || RELEASE_DELAY_US >= (1 << TIMER_W) ||
      IRQ_W < 1) begin : g_chk
    $error("bad parameter");
  end

  // register hit: aligned byte address is four times index
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                   input logic [7:0]        idx);
    reg_hit = (a[ADDR_W-1:2] == (ADDR_W-2)'(idx)) && (a[1:0] == 2'h0);
  endfunction

  // power mode decode
  function automatic logic is_idle(input logic [7:0] m);
    is_idle = (m == PMODE_IDLE);
  endfunction

  function automatic logic is_stop(input logic [7:0] m);
    is_stop = (m == PMODE_STOP);
  endfunction

  // pin glitch filter
  reset_noise_filter #(
    .FILTER_CYCLES (NOISE_CYCLES)
  ) u_filter (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .pin_n_i (reset_src_i.pin_n),
    .pin_n_o (pin_filt_n)
  );

  // shared boot and release timer
  interval_timer #(
    .WIDTH (TIMER_W)
  ) u_timer (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .clear_i (timer_clear),
    .tick_i  (us_tick),
    .limit_i (timer_limit),
    .done_o  (timer_done)
  );

  assign us_tick     = (st_r.div_cnt == DIV_W'(US_TICK_CYCLES - 1));
  assign timer_limit = (st_r.seq == SEQ_POR_WAIT) ?
                       TIMER_W'(POWERUP_DELAY_US) :
                       TIMER_W'(RELEASE_DELAY_US);

  // next state: sequencing, modes, registers
  always_comb begin
    logic       por;
    logic       pin_rst;
    logic       wdt_rst;
    logic       bod_rst;
    logic       dbg_rst;
    logic       hold;
    logic       irq_wake;
    logic [7:0] wd;
    logic [7:0] clr;
    logic [7:0] set;
    por      = reset_src_i.poweron;
    pin_rst  = !pin_filt_n;                                       // R16
    wdt_rst  = reset_src_i.watchdog_ovf &&
               st_r.wdt_ctrl[WDT_EN_BIT];                         // R10
    bod_rst  = reset_src_i.brownout &&
               !st_r.brownout[BO_DIS_BIT];                        // R11
    dbg_rst  = reset_src_i.debug_req;
    hold     = pin_rst || wdt_rst || bod_rst || dbg_rst;          // R09
    irq_wake = |(irq_request_i & irq_enable_i);
    wd       = hwdata_i[7:0];
    clr      = 8'h00;
    set      = 8'h00;
    st_nxt   = st_r;
    st_nxt.start    = 1'b0;
    st_nxt.wake     = 1'b0;
    st_nxt.wake_isr = 1'b0;

    // microsecond tick divider
    st_nxt.div_cnt = us_tick ? '0 : st_r.div_cnt + DIV_W'(1);

    // bus data phase: byte writes
    if (st_r.wr_pend) begin
      if (reg_hit(st_r.addr, IDX_POWER_MODE)) begin
        st_nxt.power_mode = wd;
      end
      if (reg_hit(st_r.addr, IDX_BROWNOUT)) begin
        st_nxt.brownout = wd & BROWNOUT_MASK;                    // R18
      end
      if (reg_hit(st_r.addr, IDX_LOWVOLT)) begin
        st_nxt.lowvolt = wd & LOWVOLT_MASK;
      end
      if (reg_hit(st_r.addr, IDX_WDT_CTRL)) begin
        st_nxt.wdt_ctrl = wd & WDT_CTRL_MASK;
      end
      if (reg_hit(st_r.addr, IDX_CAUSE)) begin
        clr = ~wd & CAUSE_IMPL_MASK;                              // R25
      end
    end

    // wake on any enabled interrupt
    if (st_r.seq == SEQ_RUN &&
        (is_idle(st_r.power_mode) || is_stop(st_r.power_mode)) &&
        irq_wake) begin                                           // R02
      st_nxt.power_mode = PMODE_NORMAL;                           // R06
      st_nxt.wake       = 1'b1;
      st_nxt.wake_isr   = global_interrupt_enable_i;              // R01
      if (is_stop(st_r.power_mode) &&
          st_r.brownout[BO_STOP_EN_BIT]) begin
        st_nxt.brownout[BO_DIS_BIT] = 1'b0;
      end
    end

    // reset sequencer
    unique case (st_r.seq)
      SEQ_POR_WAIT: begin
        if (timer_done) begin
          st_nxt.seq = SEQ_CONFIG;                                // R13
        end
      end
      SEQ_CONFIG: begin
        st_nxt.config_opt = config_option_i;                      // R14
        st_nxt.cfg_valid  = 1'b1;
        st_nxt.seq        = SEQ_STABILIZE;
      end
      SEQ_STABILIZE: begin
        if (timer_done && !hold) begin
          st_nxt.seq      = SEQ_PROCESS;                          // R15
          st_nxt.proc_cnt = '0;
        end
      end
      SEQ_PROCESS: begin
        if (st_r.proc_cnt == 3'(RESET_PROC_CYCLES - 1)) begin
          st_nxt.seq   = SEQ_RUN;                                 // R17
          st_nxt.start = 1'b1;
        end else begin
          st_nxt.proc_cnt = st_r.proc_cnt + 3'h1;
        end
      end
      SEQ_RUN: begin
      end
    endcase

    // other resets: own flag only, level kept
    if (hold && !por) begin
      set[CAUSE_PIN_BIT] = pin_rst;                               // R20
      set[CAUSE_WDT_BIT] = wdt_rst;                               // R21
      set[CAUSE_DBG_BIT] = dbg_rst;                               // R22
      set[CAUSE_BOD_BIT] = bod_rst;                               // R24
      if (st_r.seq != SEQ_POR_WAIT && st_r.seq != SEQ_CONFIG) begin
        st_nxt.seq = SEQ_STABILIZE;
      end
      st_nxt.power_mode = PMODE_NORMAL;
      st_nxt.lowvolt    = LOWVOLT_RESET;
      st_nxt.wdt_ctrl   = WDT_CTRL_RESET;
      st_nxt.brownout   = st_r.brownout & BROWNOUT_LVL_MASK;
    end

    // set wins over clear
    st_nxt.cause = ((st_r.cause & ~clr) | set) & CAUSE_IMPL_MASK; // R23

    // power-on restarts boot
    if (por) begin
      st_nxt.seq        = SEQ_POR_WAIT;
      st_nxt.cause      = CAUSE_RESET;                            // R19
      st_nxt.power_mode = PMODE_NORMAL;
      st_nxt.brownout   = BROWNOUT_RESET;
      st_nxt.lowvolt    = LOWVOLT_RESET;
      st_nxt.wdt_ctrl   = WDT_CTRL_RESET;
      st_nxt.cfg_valid  = 1'b0;
    end

    // cpu reset load until release
    if (st_nxt.seq != SEQ_RUN) begin
      st_nxt.boot = '{pc: PC_RESET, acc: ACC_RESET, sp: SP_RESET}; // R08
    end

    // bus address phase; read from updated registers
    st_nxt.wr_pend = 1'b0;
    if (hsel_i && hready_i && htrans_i[1]) begin
      st_nxt.addr    = haddr_i;
      st_nxt.wr_pend = hwrite_i && (hsize_i == HSIZE_WORD);
      st_nxt.rdata   = 32'h0000_0000;
      if (!hwrite_i) begin
        if (reg_hit(haddr_i, IDX_POWER_MODE)) begin
          st_nxt.rdata[7:0] = st_nxt.power_mode;
        end
        if (reg_hit(haddr_i, IDX_BROWNOUT)) begin
          st_nxt.rdata[7:0] = st_nxt.brownout;
        end
        if (reg_hit(haddr_i, IDX_LOWVOLT)) begin
          st_nxt.rdata[7:0] = st_nxt.lowvolt;
        end
        if (reg_hit(haddr_i, IDX_WDT_CTRL)) begin
          st_nxt.rdata[7:0] = st_nxt.wdt_ctrl;
        end
        if (reg_hit(haddr_i, IDX_CAUSE)) begin
          st_nxt.rdata[7:0] = st_nxt.cause;
        end
      end
    end

    // timer restarts on state change or held source
    timer_clear = (st_nxt.seq != st_r.seq) || (hold && !por) || por;
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      st_r            <= '0;
      st_r.seq        <= SEQ_POR_WAIT;
      st_r.cause      <= CAUSE_RESET;
      st_r.power_mode <= PMODE_NORMAL;
      st_r.brownout   <= BROWNOUT_RESET;
      st_r.lowvolt    <= LOWVOLT_RESET;
      st_r.wdt_ctrl   <= WDT_CTRL_RESET;
      st_r.boot       <= '{pc: PC_RESET, acc: ACC_RESET, sp: SP_RESET};
    end else begin
      st_r <= st_nxt;
    end
  end

  // zero-wait OKAY answers
  assign hreadyout_o = 1'b1;
  assign hresp_o     = HRESP_OKAY;
  assign hrdata_o    = st_r.rdata;

  // status outputs
  assign system_reset_o = (st_r.seq != SEQ_RUN);                  // R09
  assign cpu_start_o    = st_r.start;
  assign wake_o         = st_r.wake;
  assign wake_to_isr_o  = st_r.wake_isr;
  assign cpu_boot_o     = st_r.boot;

  // clock gating from power mode
  assign power_ctl_o.cpu_halt =
    is_idle(st_r.power_mode) || is_stop(st_r.power_mode);         // R03
  assign power_ctl_o.clock_stop      = is_stop(st_r.power_mode);  // R04
  assign power_ctl_o.periph_clock_en = !is_stop(st_r.power_mode); // R05

  // configuration and detector control
  assign config_o                = st_r.config_opt;
  assign config_valid_o          = st_r.cfg_valid;
  assign brownout_level_select_o =
    st_r.brownout[BO_LVL_LSB +: BO_LVL_W];                        // R18
  assign brownout_enable_o       = !st_r.brownout[BO_DIS_BIT];
  assign lowvolt_indicator_o     = st_r.lowvolt;
endmodule
`default_nettype wire

/* verilog/reset_noise_filter.sv */
`default_nettype none
module reset_noise_filter #(
  parameter int FILTER_CYCLES = pmrc_pkg::NOISE_CYCLES
) (
  input  wire logic clock_i,   // system clock
  input  wire logic rst_i,     // async reset, active high
  input  wire logic pin_n_i,   // raw reset pin level
  output logic      pin_n_o    // filtered pin level
);
  import pmrc_pkg::*;

  localparam int CNT_W = $clog2(FILTER_CYCLES + 1);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             level;
  } filt_s;

  filt_s st_r;
  filt_s st_nxt;

  if (FILTER_CYCLES < 2) begin : g_chk
    $error("filter length too short");
  end

  // pass a change only after a full window
  always_comb begin
    st_nxt = st_r;
    if (pin_n_i == st_r.level) begin
      st_nxt.cnt = '0;
    end else if (st_r.cnt == CNT_W'(FILTER_CYCLES - 1)) begin
      st_nxt.cnt   = '0;
      st_nxt.level = pin_n_i; // R12
    end else begin
      st_nxt.cnt = st_r.cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= '{cnt: '0, level: 1'b1};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pin_n_o = st_r.level;
endmodule
`default_nettype wire
